/* shared/sasm_pkg.sv */
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
package sasm_pkg;
    //------------------------------------------------------------
    // Data format
    //------------------------------------------------------------
    localparam int              RESULT_W     = 14;
    localparam logic [13:0]     CODE_NEG_FS  = 14'h2000;
    localparam logic [13:0]     CODE_MID     = 14'h0000;
    localparam logic [13:0]     CODE_POS_FS  = 14'h1FFF;
    localparam logic [13:0]     RESULT_RESET = 14'h0000;
    // Marker delivered after a frame cut short before conversion end
    localparam logic [13:0]     INVALID_WORD = 14'h3FFF;

    //------------------------------------------------------------
    // Clock counts within a frame
    //------------------------------------------------------------
    localparam int              CNT_W          = 7;
    localparam logic [6:0]      CNT_MAX        = 7'h7F;
    localparam logic [6:0]      CNV_CLOCKS     = 7'h12;
    localparam logic [6:0]      CAL_CLOCKS_PUP = 7'h18;
    localparam logic [6:0]      CAL_CLOCKS_RUN = 7'h40;
    localparam logic [6:0]      CAL_START_CNT  = 7'h13;
    localparam logic [6:0]      LAST_BIT_RISE  = 7'h0F;

    //------------------------------------------------------------
    // Timing
    //------------------------------------------------------------
    localparam int              CLK_PERIOD_NS       = 10;
    localparam int              MIN_ACQUIRE_TIME_NS = 95;
    localparam int              MIN_ACQUIRE_CYCLES  =
        (MIN_ACQUIRE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int              SCLK_HALF_DEFAULT   = 6;

    //------------------------------------------------------------
    // State machines
    //------------------------------------------------------------
    typedef enum logic [1:0] {
        acquire_state,
        convert_state,
        offset_cal_state
    } sasm_dev_state_t;

    typedef enum logic [2:0] {
        host_idle,
        host_lead,
        host_low,
        host_high,
        host_acq
    } sasm_host_state_t;
endpackage : sasm_pkg

/* shared/sasm_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface sasm_if;
    logic cs_n;
    logic sclk;
    logic sdo;
    logic sdo_oe;
    logic sdo_line;

    // Released line is pulled low
    assign sdo_line = sdo_oe & sdo;

    modport device (
        input  cs_n,
        input  sclk,
        output sdo,
        output sdo_oe
    );
    modport host (
        output cs_n,
        output sclk,
        input  sdo_line
    );
endinterface : sasm_if
`default_nettype wire

/* rtl/sasm_device.sv */
`timescale 1ns/1ns
`default_nettype none
module sasm_device (
    // Clock and power-up reset
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst_n,
    // Serial link
    sasm_if.device                  link,
    // Analog stand-ins, signed codes
    input  wire logic signed [13:0] i_analog_in_pos,
    input  wire logic signed [13:0] i_analog_in_neg,
    input  wire logic signed [13:0] i_internal_offset,
    // Status
    output logic                    o_caps_connected,
    output logic                    o_offset_calibrated
);
    //------------------------------------------------------------
    // Link synchronisers
    //------------------------------------------------------------
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic sclk_s1_q;
    logic sclk_s2_q;
    logic sclk_s3_q;

    // Two stages before use, third stage only for edge detection
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            cs_s3_q   <= 1'b1;
            sclk_s1_q <= 1'b1;
            sclk_s2_q <= 1'b1;
            sclk_s3_q <= 1'b1;
        end else begin
            cs_s1_q   <= link.cs_n;
            cs_s2_q   <= cs_s1_q;
            cs_s3_q   <= cs_s2_q;
            sclk_s1_q <= link.sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
        end
    end

    //------------------------------------------------------------
    // Edge decode
    //------------------------------------------------------------
    wire cs_fall;
    wire cs_rise;
    wire sclk_fall;
    wire sclk_rise;

    assign cs_fall   = cs_s3_q & ~cs_s2_q;
    assign cs_rise   = ~cs_s3_q & cs_s2_q;
    // clock counts only inside a frame
    assign sclk_fall = sclk_s3_q & ~sclk_s2_q & ~cs_s2_q;
    assign sclk_rise = ~sclk_s3_q & sclk_s2_q & ~cs_s2_q;

    //------------------------------------------------------------
    // Falling edge counter
    //------------------------------------------------------------
    logic [6:0] fall_cnt_q;
    logic       first_frame_q;
    wire  [6:0] fall_cnt_inc;
    wire  [6:0] cal_target;

    assign fall_cnt_inc = (fall_cnt_q == sasm_pkg::CNT_MAX) ? fall_cnt_q
                                                            : fall_cnt_q + 7'h01;
    assign cal_target   = first_frame_q ? sasm_pkg::CAL_CLOCKS_PUP
                                        : sasm_pkg::CAL_CLOCKS_RUN;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            fall_cnt_q <= 7'h00;
        end else if (cs_fall) begin
            fall_cnt_q <= 7'h00;
        end else if (sclk_fall) begin
            fall_cnt_q <= fall_cnt_inc;
        end
    end

    // first frame flag ends with first frame
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            first_frame_q <= 1'b1;
        end else if (cs_rise) begin
            first_frame_q <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // State machine
    //------------------------------------------------------------
    sasm_pkg::sasm_dev_state_t state_q;
    sasm_pkg::sasm_dev_state_t state_d;
    wire conv_done;
    wire cal_enter;
    wire cal_done;

    // conversion ends on the 18th falling edge
    assign conv_done = (state_q == sasm_pkg::convert_state) & sclk_fall &
                       (fall_cnt_inc == sasm_pkg::CNV_CLOCKS);
    // A clock beyond the conversion is taken as a calibration request
    assign cal_enter = (state_q == sasm_pkg::acquire_state) & sclk_fall &
                       (fall_cnt_inc == sasm_pkg::CAL_START_CNT);
    // calibration completes at 24 or 64 clocks
    assign cal_done  = (state_q == sasm_pkg::offset_cal_state) & sclk_fall &
                       (fall_cnt_inc == cal_target);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            sasm_pkg::acquire_state: begin
                if (cs_fall) begin
                    state_d = sasm_pkg::convert_state;
                end else if (cal_enter) begin
                    state_d = sasm_pkg::offset_cal_state;
                end
            end
            sasm_pkg::convert_state: begin
                // done, or cut short by select rise
                if (conv_done || cs_rise) begin
                    state_d = sasm_pkg::acquire_state;
                end
            end
            sasm_pkg::offset_cal_state: begin
                if (cal_done || cs_rise) begin
                    state_d = sasm_pkg::acquire_state;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_q          <= sasm_pkg::acquire_state;
            o_caps_connected <= 1'b1;
        end else begin
            state_q          <= state_d;
            o_caps_connected <= (state_d == sasm_pkg::acquire_state);
        end
    end

    //------------------------------------------------------------
    // Sampling, conversion and offset correction
    //------------------------------------------------------------
    logic signed [14:0] sample_q;
    logic signed [13:0] offset_q;
    logic        [13:0] result_q;
    wire  signed [15:0] corrected;
    wire         [13:0] conv_code;
    wire                sat_hi;
    wire                sat_lo;

    assign corrected = {sample_q[14], sample_q} - {{2{offset_q[13]}}, offset_q};
    assign sat_hi    = ~corrected[15] & (corrected[14:13] != 2'b00);
    assign sat_lo    = corrected[15] & (corrected[14:13] != 2'b11);
    // two's complement, clipped to full scale
    assign conv_code = sat_hi ? sasm_pkg::CODE_POS_FS :
                       sat_lo ? sasm_pkg::CODE_NEG_FS : corrected[13:0];

    // sample difference held at select fall
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sample_q <= 15'h0000;
        end else if (cs_fall && state_q == sasm_pkg::acquire_state) begin
            sample_q <= {i_analog_in_pos[13], i_analog_in_pos} -
                        {i_analog_in_neg[13], i_analog_in_neg};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            offset_q            <= 14'h0000;
            o_offset_calibrated <= 1'b0;
        end else if (cal_done) begin
            offset_q            <= i_internal_offset;
            o_offset_calibrated <= 1'b1;
        end
    end

    // starts at zero, short frame leaves invalid word
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            result_q <= sasm_pkg::RESULT_RESET;
        end else if (conv_done) begin
            result_q <= conv_code;
        end else if (cs_rise && state_q == sasm_pkg::convert_state) begin
            result_q <= sasm_pkg::INVALID_WORD;
        end
    end

    //------------------------------------------------------------
    // Serial output
    //------------------------------------------------------------
    logic [13:0] shift_q;
    logic        sdo_q;
    logic        sdo_oe_q;
    wire         launch;

    // no launch before the first falling edge
    assign launch = sclk_rise & (fall_cnt_q != 7'h00);

    // previous result loaded; zeros shift in behind it
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            shift_q <= 14'h0000;
        end else if (cs_fall) begin
            shift_q <= result_q;
        end else if (launch) begin
            shift_q <= {shift_q[12:0], 1'b0};
        end
    end

    // leading zero, released on select high
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sdo_q    <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else if (cs_fall || cs_rise) begin
            sdo_q    <= 1'b0;
            sdo_oe_q <= cs_fall;
        end else if (launch) begin
            sdo_q    <= shift_q[13];
        end
    end

    assign link.sdo    = sdo_q;
    assign link.sdo_oe = sdo_oe_q;
endmodule : sasm_device
`default_nettype wire

/* rtl/sasm_host.sv */
`timescale 1ns/1ns
`default_nettype none
module sasm_host #(
    parameter int SCLK_HALF      = sasm_pkg::SCLK_HALF_DEFAULT,
    parameter bit CAL_AT_POWERUP = 1'b1
) (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // Serial link
    sasm_if.host             link,
    // Frame request
    input  wire logic        i_start,
    input  wire logic [6:0]  i_num_clocks,
    // Frame result
    output logic             o_busy,
    output logic [13:0]      o_data,
    output logic             o_data_valid
);
    //------------------------------------------------------------
    // Data input synchroniser
    //------------------------------------------------------------
    logic sdo_s1_q;
    logic sdo_s2_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sdo_s1_q <= 1'b0;
            sdo_s2_q <= 1'b0;
        end else begin
            sdo_s1_q <= link.sdo_line;
            sdo_s2_q <= sdo_s1_q;
        end
    end

    //------------------------------------------------------------
    // Phase timing and decode
    //------------------------------------------------------------
    // Each bit is taken on the last cycle of a high phase. Three device and two host
    // flip-flops lie in that loop, so a SCLK_HALF below 6 samples too early.
    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
    localparam logic [7:0] ACQ_LAST  = 8'(sasm_pkg::MIN_ACQUIRE_CYCLES - 1);
    localparam logic [4:0] BITS_FULL = 5'(sasm_pkg::RESULT_W);

    sasm_pkg::sasm_host_state_t state_q;
    sasm_pkg::sasm_host_state_t state_d;
    logic [7:0]                 tick_q;
    logic [6:0]                 todo_q;
    logic [6:0]                 falls_q;
    logic [4:0]                 bits_q;
    logic [13:0]                rx_q;
    logic                       cal_pending_q;
    logic                       cs_n_q;
    logic                       sclk_q;
    wire  [7:0]                 tick_next;
    wire  [6:0]                 req_clocks;
    wire  [13:0]                rx_next;
    wire                        tick_end;
    wire                        acq_end;
    wire                        go;
    wire                        no_clocks;
    wire                        last_clock;
    wire                        fall_now;
    wire                        take_bit;
    wire                        deliver;
    wire                        in_frame_d;
    wire                        sclk_d;

    // Phase counter restarts on every state change
    assign tick_next  = (state_d != state_q) ? 8'h00 : tick_q + 8'h01;
    assign tick_end   = (tick_q == HALF_LAST);
    // select held high for the acquisition time
    assign acq_end    = (tick_q == ACQ_LAST);
    // power-up calibration asks for 24 clocks, otherwise the caller's i_num_clocks
    assign req_clocks = cal_pending_q ? sasm_pkg::CAL_CLOCKS_PUP : i_num_clocks;
    assign go         = (state_q == sasm_pkg::host_idle) & (i_start | cal_pending_q);
    // exactly the requested number of falling edges
    assign no_clocks  = (todo_q == 7'h00);
    assign last_clock = (falls_q == todo_q);
    assign fall_now   = (state_q != sasm_pkg::host_low) & (state_d == sasm_pkg::host_low);
    assign take_bit   = (state_q == sasm_pkg::host_high) & tick_end & (bits_q != BITS_FULL);
    assign rx_next    = {rx_q[12:0], sdo_s2_q};
    // Only a frame that carried the whole word delivers it
    assign deliver    = (state_q == sasm_pkg::host_acq) & (tick_q == 8'h00) &
                        (bits_q == BITS_FULL);
    // select low from lead-in to the last high phase
    assign in_frame_d = (state_d == sasm_pkg::host_lead) | (state_d == sasm_pkg::host_low) |
                        (state_d == sasm_pkg::host_high);
    assign sclk_d     = (state_d != sasm_pkg::host_low);

    //------------------------------------------------------------
    // Frame sequencer
    //------------------------------------------------------------
    // Clock idles high so the device sees no edge outside a frame
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            sasm_pkg::host_idle: begin
                if (go) begin
                    state_d = sasm_pkg::host_lead;
                end
            end
            sasm_pkg::host_lead: begin
                if (tick_end && no_clocks) begin
                    state_d = sasm_pkg::host_acq;
                end else if (tick_end) begin
                    state_d = sasm_pkg::host_low;
                end
            end
            sasm_pkg::host_low: begin
                if (tick_end) begin
                    state_d = sasm_pkg::host_high;
                end
            end
            sasm_pkg::host_high: begin
                if (tick_end && last_clock) begin
                    state_d = sasm_pkg::host_acq;
                end else if (tick_end) begin
                    state_d = sasm_pkg::host_low;
                end
            end
            sasm_pkg::host_acq: begin
                if (acq_end) begin
                    state_d = sasm_pkg::host_idle;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_q <= sasm_pkg::host_idle;
            tick_q  <= 8'h00;
        end else begin
            state_q <= state_d;
            tick_q  <= tick_next;
        end
    end

    // Request latched at start, falling edges counted as issued
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cal_pending_q <= CAL_AT_POWERUP;
            todo_q        <= 7'h00;
            falls_q       <= 7'h00;
        end else if (go) begin
            cal_pending_q <= 1'b0;
            todo_q        <= req_clocks;
            falls_q       <= 7'h00;
        end else if (fall_now) begin
            falls_q       <= falls_q + 7'h01;
        end
    end

    // Receive shifter, MSB first; bits after the word are ignored
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            bits_q <= 5'h00;
            rx_q   <= 14'h0000;
        end else if (go) begin
            bits_q <= 5'h00;
        end else if (take_bit) begin
            bits_q <= bits_q + 5'h01;
            rx_q   <= rx_next;
        end
    end

    //------------------------------------------------------------
    // Registered outputs
    //------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cs_n_q       <= 1'b1;
            sclk_q       <= 1'b1;
            o_busy       <= 1'b0;
            o_data_valid <= 1'b0;
        end else begin
            cs_n_q       <= ~in_frame_d;
            sclk_q       <= sclk_d;
            o_busy       <= (state_d != sasm_pkg::host_idle);
            o_data_valid <= deliver;
        end
    end

    // Word stands until the next complete frame
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_data <= 14'h0000;
        end else if (deliver) begin
            o_data <= rx_q;
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
endmodule : sasm_host
`default_nettype wire

/* verif/sasm_checker_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module sasm_checker_sva (
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    // Serial link
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    localparam int ACQ_CYC = sasm_pkg::MIN_ACQUIRE_CYCLES;
    logic       sclk_q;
    logic [6:0] falls_q;
    logic [6:0] hi_q;
    logic       first_q;

    // Frame bookkeeping; hi_q saturates so a long idle never wraps
    always_ff @(posedge i_clk_sys) begin
        sclk_q <= sclk;
        if (!i_rst_n) begin
            falls_q <= 7'h00;
            hi_q    <= 7'h7F;
            first_q <= 1'b1;
        end else begin
            falls_q <= cs_n ? 7'h00 : falls_q + 7'((sclk_q && !sclk) ? 1 : 0);
            hi_q    <= !cs_n ? 7'h00 : hi_q + 7'((hi_q != 7'h7F) ? 1 : 0);
            first_q <= first_q && !(cs_n && hi_q == 7'h00);
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_sdo_released: assert property (cs_n && hi_q >= 7'h04 |-> !sdo_oe)
        else $error("data line driven while deselected");
    a_lead_zero: assert property ($fell(cs_n) |-> ##[1:6] (sdo_oe && !sdo))
        else $error("no leading zero after select fall");
    a_zero_tail: assert property (falls_q >= 7'h11 && sdo_oe |-> !sdo)
        else $error("non-zero bit after result word");
    a_first_zero: assert property (first_q && sdo_oe |-> !sdo)
        else $error("first frame is not all zeros");
    a_acq_gap: assert property ($fell(cs_n) |-> hi_q >= ACQ_CYC)
        else $error("acquisition gap too short");
    a_clock_idle: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> $stable(sclk))
        else $error("serial clock moves outside frame");
    a_clock_high: assert property ($rose(sclk) |=> sclk[*5])
        else $error("serial clock high phase too short");
    a_bit_launch: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> sclk)
        else $error("data bit launched off the rising phase");

    // Main scenarios reached
    c_frame: cover property ($fell(cs_n));
    c_cal_pup: cover property ($rose(cs_n) && falls_q == 7'h18);
    c_cal_run: cover property ($rose(cs_n) && falls_q == 7'h40);
endmodule : sasm_checker_sva
`default_nettype wire

/* verif/sar_adc_serial_state_machine_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module sar_adc_serial_state_machine_bench;
    logic               i_clk_sys    = 1'b0;
    logic               i_rst_n      = 1'b0;
    logic               i_start      = 1'b0;
    logic [6:0]         i_num_clocks = 7'h00;
    logic signed [13:0] pos          = 14'h0000;
    logic signed [13:0] neg          = 14'h0000;
    logic signed [13:0] offs         = 14'h0005;
    logic               o_busy;
    logic [13:0]        o_data;
    logic               o_data_valid;
    logic               caps;
    logic               cal_done;
    logic [13:0]        got_q        = 14'h0000;
    logic [13:0]        tp[4]        = '{14'h1FFF, 14'h0000, 14'h2000, 14'h0123};
    logic [13:0]        tn[4]        = '{14'h0000, 14'h0000, 14'h0000, 14'h0100};
    // Difference less the calibrated offset of 5, clipped at full scale
    logic [13:0]        exp_w[4]     = '{14'h1FFA, 14'h3FFB, 14'h2000, 14'h001E};
    int                 n_mismatch   = 0;
    int                 check_count  = 0;

    sasm_if link_if ();
    sasm_device sasm_device_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .link(link_if),
        .i_analog_in_pos(pos), .i_analog_in_neg(neg), .i_internal_offset(offs),
        .o_caps_connected(caps), .o_offset_calibrated(cal_done));
    sasm_host #(.SCLK_HALF(6), .CAL_AT_POWERUP(1'b0)) sasm_host_inst (.i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n), .link(link_if), .i_start(i_start), .i_num_clocks(i_num_clocks),
        .o_busy(o_busy), .o_data(o_data), .o_data_valid(o_data_valid));
    sasm_checker_sva sasm_checker_sva_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .cs_n(link_if.cs_n), .sclk(link_if.sclk), .sdo(link_if.sdo), .sdo_oe(link_if.sdo_oe));

    always #5 i_clk_sys = ~i_clk_sys;

    // Keep the last word the host delivered
    always @(posedge i_clk_sys) begin
        if (o_data_valid === 1'b1) begin
            got_q <= o_data;
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic do_reset;
        i_rst_n = 1'b0;
        repeat (12) @(posedge i_clk_sys);
        #1 i_rst_n = 1'b1;
    endtask : do_reset

    // One frame of n clocks; waits for the host to go busy and idle again
    task automatic frame(input logic [6:0] n);
        int t;
        @(posedge i_clk_sys);
        #1 i_num_clocks = n;
        i_start = 1'b1;
        @(posedge i_clk_sys);
        #1 i_start = 1'b0;
        t = 0;
        while (o_busy !== 1'b1 && t < 20) begin
            @(posedge i_clk_sys);
            t++;
        end
        while (o_busy !== 1'b0 && t < 3000) begin
            @(posedge i_clk_sys);
            t++;
        end
        check(14'(t < 3000), 14'h0001);
        #1;
    endtask : frame

    initial begin
        do_reset();
        check(14'(link_if.sdo_oe), 14'h0000);
        check(14'(caps), 14'h0001);
        frame(7'h14);
        check(got_q, 14'h0000);
        check(14'(caps), 14'h0001);
        check(14'(cal_done), 14'h0000);
        do_reset();
        frame(7'h18);
        check(got_q, 14'h0000);
        check(14'(cal_done), 14'h0001);
        check(14'(caps), 14'h0001);
        // Each frame returns the word converted in the frame before it
        for (int i = 0; i < 4; i++) begin
            pos = tp[i];
            neg = tn[i];
            frame(7'h12);
            if (i > 0) check(got_q, exp_w[i-1]);
        end
        frame(7'h40);
        check(got_q, exp_w[3]);
        pos = 14'h0ABC;
        neg = 14'h0000;
        frame(7'h12);
        frame(7'h1E);
        check(got_q, 14'h0AB7);
        check(14'(caps), 14'h0001);
        frame(7'h0A);
        frame(7'h12);
        check(got_q, sasm_pkg::INVALID_WORD);
        report_and_stop();
    end

    // Hang guard, well beyond the eleven frames above
    initial begin
        repeat (60000) @(posedge i_clk_sys);
        n_mismatch++;
        report_and_stop();
    end
endmodule : sar_adc_serial_state_machine_bench
`default_nettype wire
